/* hdl/cktw_clock_tree.sv */
// clock tree: pll model, low-speed ticks, tick wheels, watch second,
// master/bus/cpu clocks, digital and analog dividers, usb clock select
// assumes oscillator and fabric clocks arrive asynchronously on pins
// and every generated clock leaves as a tick or a level on clk
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - pll multiplies reference by feedback over input ratio, 4032 ratios
// - lock bit sets 250 us after enable or setting change
// - pll reference is main oscillator, fast crystal or routed clock
// - lock level is also driven out to the routing fabric
// - low-speed block gives 1 kHz, 33 kHz and 100 kHz ticks
// - 33 kHz tick is the 100 kHz tick divided by three
// - central tick wheel is a 13-bit counter on the 1 kHz tick
// - central wheel stops only in hibernate or debug halt
// - central wheel gives periodic interrupt, wake, and firmware clear
// - fast wheel is 5-bit on 100 kHz, wraps at programmable terminal
// - fast wheel pulses an interrupt at terminal count when enabled
// - watch crystal gives one-second tick and feeds sleep timer
// - eight direct routed clocks feed the eight digital dividers
// - master selector picks one of seven sources as master clock
// - 16-bit bus divider from master; cpu divider from bus clock
// - eight programmable 16-bit digital dividers from any source
// - four 16-bit analog dividers with programmable edge skew
// - each divider: 8-way select, ratio two up, resync, deglitch
// - digital dividers 0 to 3 feed slot eight of the four analog dividers
// - usb clock is routed 48 MHz or doubled 24 MHz source
// - doubler doubles main oscillator, fast crystal or routed clock
module cktw_clock_tree #(
  parameter int LOCK_CYCLES = cktw_pkg::PLL_LOCK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // asynchronous clock inputs
  input wire logic internalMainOsc,
  input wire logic fastCrystalOsc,
  input wire logic routedClk,
  input wire logic lowSpeedOsc,
  input wire logic watchCrystalOsc,
  input wire logic routedUsbClk,
  input wire logic [cktw_pkg::N_DIG-1:0] routedDirect,
  // pll
  input wire logic pllEn,
  input wire logic [1:0] pllRefSel,
  input wire logic [cktw_pkg::PLL_FLD_W-1:0] pllInDiv,
  input wire logic [cktw_pkg::PLL_FLD_W-1:0] pllFbDiv,
  output logic pllLocked,
  output logic pllLockRouted,
  // low-speed ticks
  output logic slowTickClock,
  output logic crystalSubstituteTick,
  output logic lowPowerMasterTick,
  // central tick wheel
  input wire logic hibernate,
  input wire logic debugHalt,
  input wire logic ctwClear,
  input wire logic ctwIntEn,
  input wire logic ctwWakeEn,
  input wire logic [cktw_pkg::CTW_SEL_W-1:0] ctwIntSel,
  output logic [cktw_pkg::CTW_W-1:0] ctwCount,
  output logic ctwIntr,
  output logic ctwWake,
  // fast tick wheel
  input wire logic ftwEn,
  input wire logic ftwIntEn,
  input wire logic [cktw_pkg::FTW_W-1:0] ftwTerminal,
  output logic [cktw_pkg::FTW_W-1:0] ftwCount,
  output logic ftwIntr,
  // watch crystal
  output logic rtcSecond,
  output logic sleepTimerTick,
  // master, bus and cpu clocks
  input wire logic [cktw_pkg::SRC_SEL_W-1:0] masterSel,
  input wire logic [cktw_pkg::DIV_W-1:0] busDiv,
  input wire logic [cktw_pkg::CPU_DIV_W-1:0] cpuDiv,
  output logic masterTick,
  output logic busClk,
  output logic cpuClk,
  // digital dividers
  input wire logic [cktw_pkg::N_DIG*cktw_pkg::SRC_SEL_W-1:0] digSel,
  input wire logic [cktw_pkg::N_DIG*cktw_pkg::DIV_W-1:0] digDiv,
  output logic [cktw_pkg::N_DIG-1:0] digClk,
  // analog dividers
  input wire logic [cktw_pkg::N_ANA*cktw_pkg::SRC_SEL_W-1:0] anaSel,
  input wire logic [cktw_pkg::N_ANA*cktw_pkg::DIV_W-1:0] anaDiv,
  input wire logic [cktw_pkg::N_ANA*cktw_pkg::SKEW_W-1:0] anaSkew,
  output logic [cktw_pkg::N_ANA-1:0] anaClk,
  // doubler and usb
  input wire logic [1:0] dblSel,
  input wire logic usbSel,
  output logic usbClkTick
);
  import cktw_pkg::*;

  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);

  // input synchronisers: a change counts once stages two and three agree
  logic [N_ASYNC-1:0] syncA;
  logic [N_ASYNC-1:0] syncB;
  logic [N_ASYNC-1:0] syncC;
  logic [N_ASYNC-1:0] stable;
  logic [N_ASYNC-1:0] riseTick;
  logic [N_ASYNC-1:0] edgeTick;

  wire [N_ASYNC-1:0] asyncIn = {routedDirect, routedUsbClk, watchCrystalOsc,
    lowSpeedOsc, routedClk, fastCrystalOsc, internalMainOsc};
  wire [N_ASYNC-1:0] agree = ~(syncB ^ syncC);
  wire [N_ASYNC-1:0] changed = agree & (syncC ^ stable);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
      stable <= '0;
      riseTick <= '0;
      edgeTick <= '0;
    end else begin
      syncA <= asyncIn;
      syncB <= syncA;
      syncC <= syncB;
      stable <= (stable & ~agree) | (syncC & agree);
      riseTick <= changed & syncC;
      edgeTick <= changed;
    end
  end

  // pll: credit accumulator adds feedback ratio per reference tick and
  // spends the input ratio per output tick
  logic [PLL_CRED_W-1:0] credit;
  logic [LOCK_W-1:0] lockCnt;
  logic [2*PLL_FLD_W+1:0] pllCfg;
  logic pllTick;

  wire refTick = (pllRefSel == REF_IMO) ? riseTick[A_IMO] :
                 (pllRefSel == REF_ECO) ? riseTick[A_ECO] :
                 (pllRefSel == REF_ROUTED) ? riseTick[A_ROUTED] : 1'b0;
  wire [PLL_RAT_W-1:0] qRatio = {1'b0, pllInDiv} + PLL_RAT_W'(1);
  wire [PLL_RAT_W-1:0] pRatio = (pllFbDiv == '0) ? PLL_RAT_W'(PLL_FB_MIN)
                                : {1'b0, pllFbDiv} + PLL_RAT_W'(1);
  wire [2*PLL_FLD_W+1:0] cfgNow = {pllRefSel, pllInDiv, pllFbDiv};
  wire emit = pllEn && (credit >= PLL_CRED_W'(qRatio));
  wire [PLL_CRED_W:0] credSum = {1'b0, credit}
    + (refTick ? (PLL_CRED_W+1)'(pRatio) : '0)
    - (emit ? (PLL_CRED_W+1)'(qRatio) : '0);
  wire pllRestart = !pllEn || (cfgNow != pllCfg);
  assign pllLockRouted = pllLocked;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      credit <= '0;
      lockCnt <= '0;
      pllCfg <= '0;
      pllLocked <= 1'b0;
      pllTick <= 1'b0;
    end else begin
      pllCfg <= cfgNow;
      pllTick <= emit && pllLocked;
      if (pllRestart) begin
        credit <= '0;
        lockCnt <= '0;
        pllLocked <= 1'b0;
      end else begin
        credit <= credSum[PLL_CRED_W] ? PLL_CRED_MAX
                                      : credSum[PLL_CRED_W-1:0];
        if (lockCnt == LOCK_W'(LOCK_CYCLES))
          pllLocked <= 1'b1;
        else
          lockCnt <= lockCnt + LOCK_W'(1);
      end
    end
  end

  // low-speed ticks and tick wheels
  logic [SUB_W-1:0] subCnt;
  logic [SLOW_W-1:0] slowCnt;
  logic [WATCH_W-1:0] watchCnt;

  wire tick100k = riseTick[A_LOWSPD];
  wire subWrap = subCnt == SUB_W'(SUB_DIV - 1);
  wire slowWrap = slowCnt == SLOW_W'(SLOW_DIV - 1);
  wire ctwAdvance = slowTickClock && !hibernate && !debugHalt;
  wire [CTW_W-1:0] ctwNext = ctwCount + CTW_W'(1);
  wire [CTW_W-1:0] ctwMask = (CTW_W'(1) << ctwIntSel) - CTW_W'(1);
  wire ctwMatch = ctwAdvance && ((ctwNext & ctwMask) == '0);
  wire ftwWrap = ftwCount == ftwTerminal;
  wire watchWrap = watchCnt == WATCH_W'(WATCH_HZ - 1);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      subCnt <= '0;
      slowCnt <= '0;
      lowPowerMasterTick <= 1'b0;
      crystalSubstituteTick <= 1'b0;
      slowTickClock <= 1'b0;
    end else begin
      lowPowerMasterTick <= tick100k;
      crystalSubstituteTick <= tick100k && subWrap;
      slowTickClock <= tick100k && slowWrap;
      if (tick100k) begin
        subCnt <= subWrap ? '0 : subCnt + SUB_W'(1);
        slowCnt <= slowWrap ? '0 : slowCnt + SLOW_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctwCount <= '0;
      ctwIntr <= 1'b0;
      ctwWake <= 1'b0;
    end else begin
      ctwIntr <= ctwMatch && ctwIntEn;
      ctwWake <= ctwMatch && ctwWakeEn;
      if (ctwClear)
        ctwCount <= '0;
      else if (ctwAdvance)
        ctwCount <= ctwNext;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ftwCount <= '0;
      ftwIntr <= 1'b0;
    end else begin
      ftwIntr <= ftwEn && tick100k && ftwWrap && ftwIntEn;
      if (ftwEn && tick100k)
        ftwCount <= ftwWrap ? '0 : ftwCount + FTW_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      watchCnt <= '0;
      rtcSecond <= 1'b0;
      sleepTimerTick <= 1'b0;
    end else begin
      sleepTimerTick <= riseTick[A_WATCH];
      rtcSecond <= riseTick[A_WATCH] && watchWrap;
      if (riseTick[A_WATCH])
        watchCnt <= watchWrap ? '0 : watchCnt + WATCH_W'(1);
    end
  end

  wire dblTick = (dblSel == REF_IMO) ? edgeTick[A_IMO] :
                 (dblSel == REF_ECO) ? edgeTick[A_ECO] :
                 (dblSel == REF_ROUTED) ? edgeTick[A_ROUTED] : 1'b0;

  // seven general sources; slot eight is filled per divider
  wire [N_SRC-2:0] srcBase = {riseTick[A_WATCH], riseTick[A_LOWSPD],
    dblTick, pllTick, riseTick[A_ROUTED], riseTick[A_ECO],
    riseTick[A_IMO]};

  wire masterNow = (masterSel == SRC_CHAIN) ? srcBase[SRC_IMO]
                                            : srcBase[masterSel];
  logic busTick;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      masterTick <= 1'b0;
      usbClkTick <= 1'b0;
    end else begin
      masterTick <= masterNow;
      usbClkTick <= usbSel ? dblTick : riseTick[A_USB];
    end
  end

  cktw_clk_div #(.W(DIV_W), .SKW(SKEW_W)) busDivider (
    .clk(clk),
    .rst_b(rst_b),
    .srcTick({N_SRC{masterTick}}),
    .sel(SRC_IMO),
    .divisor(busDiv),
    .skew('0),
    .masterTick(masterTick),
    .clkOut(busClk),
    .outTick(busTick)
  );

  cktw_clk_div #(.W(CPU_DIV_W), .SKW(SKEW_W)) cpuDivider (
    .clk(clk),
    .rst_b(rst_b),
    .srcTick({N_SRC{busTick}}),
    .sel(SRC_IMO),
    .divisor(cpuDiv),
    .skew('0),
    .masterTick(masterTick),
    .clkOut(cpuClk),
    .outTick()
  );

  logic [N_DIG-1:0] digTick;

  // digital dividers with direct routed inputs
  for (genvar d = 0; d < N_DIG; d++) begin : gDig
    cktw_clk_div #(.W(DIV_W), .SKW(SKEW_W)) digDivider (
      .clk(clk),
      .rst_b(rst_b),
      .srcTick({riseTick[A_DIRECT+d], srcBase}),
      .sel(digSel[d*SRC_SEL_W +: SRC_SEL_W]),
      .divisor(digDiv[d*DIV_W +: DIV_W]),
      .skew('0),
      .masterTick(masterTick),
      .clkOut(digClk[d]),
      .outTick(digTick[d])
    );
  end

  // analog dividers; slot eight cascades a digital divider
  for (genvar a = 0; a < N_ANA; a++) begin : gAna
    cktw_clk_div #(.W(DIV_W), .SKW(SKEW_W)) anaDivider (
      .clk(clk),
      .rst_b(rst_b),
      .srcTick({digTick[a], srcBase}),
      .sel(anaSel[a*SRC_SEL_W +: SRC_SEL_W]),
      .divisor(anaDiv[a*DIV_W +: DIV_W]),
      .skew(anaSkew[a*SKEW_W +: SKEW_W]),
      .masterTick(masterTick),
      .clkOut(anaClk[a]),
      .outTick()
    );
  end

endmodule : cktw_clock_tree
`default_nettype wire

/* hdl/cktw_pkg.sv */
// constants shared by the clock tree and its dividers
// assumes a single 250 MHz system clock and tick-style clock sources
package cktw_pkg;

  // system clock and timing figures
  localparam int CLK_MHZ = 250;
  localparam int PLL_LOCK_US = 250;
  localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;

  // counter widths
  localparam int CTW_W = 13;
  localparam int FTW_W = 5;
  localparam int DIV_W = 16;
  localparam int CPU_DIV_W = 4;
  localparam int SKEW_W = 4;
  localparam int CTW_SEL_W = 4;
  localparam int N_DIG = 8;
  localparam int N_ANA = 4;

  // low-speed and watch crystal ratios
  localparam int SUB_DIV = 3;
  localparam int SLOW_DIV = 100;
  localparam int WATCH_HZ = 32768;
  localparam int SUB_W = 2;
  localparam int SLOW_W = 7;
  localparam int WATCH_W = 15;

  // pll divider fields: 64 input ratios x 63 feedback ratios = 4032
  localparam int PLL_FLD_W = 6;
  localparam int PLL_RAT_W = 7;
  localparam int PLL_FB_MIN = 2;
  localparam int PLL_CRED_W = 10;
  localparam logic [PLL_CRED_W-1:0] PLL_CRED_MAX = 10'h3FF;

  // divider source selector
  localparam int N_SRC = 8;
  localparam int SRC_SEL_W = 3;
  localparam int DIV_MIN = 2;

  // clock source slots of every divider selector
  localparam logic [SRC_SEL_W-1:0] SRC_IMO = 3'h0;
  localparam logic [SRC_SEL_W-1:0] SRC_ECO = 3'h1;
  localparam logic [SRC_SEL_W-1:0] SRC_ROUTED = 3'h2;
  localparam logic [SRC_SEL_W-1:0] SRC_PLL = 3'h3;
  localparam logic [SRC_SEL_W-1:0] SRC_DBL = 3'h4;
  localparam logic [SRC_SEL_W-1:0] SRC_LOWSPD = 3'h5;
  localparam logic [SRC_SEL_W-1:0] SRC_WATCH = 3'h6;
  localparam logic [SRC_SEL_W-1:0] SRC_CHAIN = 3'h7;

  // reference selections shared by pll and doubler
  localparam logic [1:0] REF_IMO = 2'h0;
  localparam logic [1:0] REF_ECO = 2'h1;
  localparam logic [1:0] REF_ROUTED = 2'h2;

  // asynchronous input slots
  localparam int A_IMO = 0;
  localparam int A_ECO = 1;
  localparam int A_ROUTED = 2;
  localparam int A_LOWSPD = 3;
  localparam int A_WATCH = 4;
  localparam int A_USB = 5;
  localparam int A_DIRECT = 6;
  localparam int N_ASYNC = A_DIRECT + N_DIG;

endpackage : cktw_pkg

/* hdl/cktw_clk_div.sv */
// one clock divider: 8-way source selector, programmable ratio,
// master-tick resynchronisation, deglitch and optional edge skew
// assumes source and master clocks arrive as one-cycle ticks on clk
`timescale 1ns/100ps
`default_nettype none

module cktw_clk_div #(
  parameter int W = 16,
  parameter int SKW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // sources and settings
  input wire logic [cktw_pkg::N_SRC-1:0] srcTick,
  input wire logic [cktw_pkg::SRC_SEL_W-1:0] sel,
  input wire logic [W-1:0] divisor,
  input wire logic [SKW-1:0] skew,
  input wire logic masterTick,
  // divided clock
  output logic clkOut,
  output logic outTick
);
  import cktw_pkg::*;

  logic [SRC_SEL_W-1:0] selReg;
  logic [W-1:0] cnt;
  logic raw;
  logic [SKW-1:0] skewCnt;

  wire selChange = sel != selReg;
  wire tickIn = srcTick[selReg];
  wire [W-1:0] ratio = (divisor < W'(DIV_MIN)) ? W'(DIV_MIN) : divisor;
  wire [W-1:0] half = ratio >> 1;
  wire [W-1:0] cntNext = (cnt == ratio - W'(1)) ? '0 : cnt + W'(1);
  wire edgeDue = masterTick && (clkOut != raw);
  wire skewDone = skewCnt == skew;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      selReg <= '0;
      cnt <= '0;
      raw <= 1'b0;
      skewCnt <= '0;
      clkOut <= 1'b0;
      outTick <= 1'b0;
    end else begin
      outTick <= edgeDue && skewDone && raw;
      if (selChange) begin
        selReg <= sel;
        cnt <= '0;
        raw <= 1'b0;
      end else if (tickIn) begin
        cnt <= cntNext;
        raw <= cntNext < half;
      end
      if (edgeDue) begin
        if (skewDone) begin
          clkOut <= raw;
          skewCnt <= '0;
        end else begin
          skewCnt <= skewCnt + SKW'(1);
        end
      end else if (clkOut == raw) begin
        skewCnt <= '0;
      end
    end
  end

endmodule : cktw_clk_div
`default_nettype wire

/* testbench/cktw_clock_tree_asserts.sv */
// concurrent checks on the clock tree ports
// assumes one clock clk and a synchronous active-low rst_b
`timescale 1ns/100ps
`default_nettype none
module cktw_clock_tree_asserts #(
  parameter int LOCK_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pll
  input wire logic pllEn,
  input wire logic pllLocked,
  input wire logic pllLockRouted,
  // low-speed ticks
  input wire logic slowTickClock,
  input wire logic crystalSubstituteTick,
  input wire logic lowPowerMasterTick,
  // central wheel
  input wire logic hibernate,
  input wire logic debugHalt,
  input wire logic ctwClear,
  input wire logic ctwIntEn,
  input wire logic [cktw_pkg::CTW_SEL_W-1:0] ctwIntSel,
  input wire logic [cktw_pkg::CTW_W-1:0] ctwCount,
  input wire logic ctwIntr,
  // fast wheel
  input wire logic ftwEn,
  input wire logic ftwIntEn,
  input wire logic [cktw_pkg::FTW_W-1:0] ftwTerminal,
  input wire logic [cktw_pkg::FTW_W-1:0] ftwCount,
  input wire logic ftwIntr
);
  import cktw_pkg::*;
  int enCnt;
  wire [CTW_W-1:0] intMask = (13'h1 << ctwIntSel) - 13'h1;
  // cycles the pll has been enabled
  always_ff @(posedge clk) begin
    if (!rst_b || !pllEn) enCnt <= 0;
    else if (enCnt < 1000) enCnt <= enCnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wheel_step;
    slowTickClock && !hibernate && !debugHalt && !ctwClear;
  endsequence
  sequence s_fast_step;
    ftwEn ##1 lowPowerMasterTick;
  endsequence
  a_slow_tick: assert property (
    slowTickClock |-> lowPowerMasterTick) else $error("stray slow tick");
  a_sub_tick: assert property (
    crystalSubstituteTick |-> lowPowerMasterTick) else $error("stray sub tick");
  a_ctw_advance: assert property (
    s_wheel_step |=> ctwCount == $past(ctwCount) + 13'h1)
    else $error("wheel did not advance");
  a_ctw_hold: assert property (
    (!slowTickClock || hibernate || debugHalt) && !ctwClear
      |=> $stable(ctwCount)) else $error("wheel moved while held");
  a_ctw_clear: assert property (
    ctwClear |=> ctwCount == '0) else $error("wheel not cleared");
  a_ctw_intr: assert property (
    s_wheel_step ##0 ctwIntEn |=> ctwIntr == ((ctwCount & intMask) == '0))
    else $error("wheel interrupt wrong");
  a_ftw_wrap: assert property (
    ftwCount == ftwTerminal ##0 s_fast_step |-> ftwCount == '0)
    else $error("fast wheel did not wrap");
  a_ftw_step: assert property (
    ftwCount != ftwTerminal ##0 s_fast_step
      |-> ftwCount == $past(ftwCount) + 5'h1) else $error("fast wheel step");
  a_ftw_intr: assert property (
    ftwIntEn ##0 ftwCount == ftwTerminal ##0 s_fast_step |-> ftwIntr)
    else $error("fast wheel interrupt missing");
  a_lock_time: assert property (
    $rose(pllLocked) |-> enCnt >= LOCK_CYCLES && enCnt <= LOCK_CYCLES + 3)
    else $error("lock at wrong time");
  a_lock_drop: assert property (
    !pllEn |-> ##[1:2] !pllLocked) else $error("lock kept when disabled");
  a_lock_route: assert property (
    pllLockRouted == pllLocked) else $error("routed lock differs");
  a_reset_clear: assert property (
    $rose(rst_b) |-> ctwCount == '0 && ftwCount == '0 && !pllLocked)
    else $error("counters not cleared");
endmodule : cktw_clock_tree_asserts
bind cktw_clock_tree cktw_clock_tree_asserts #(.LOCK_CYCLES(LOCK_CYCLES))
  u_chk (.clk(clk), .rst_b(rst_b), .pllEn(pllEn), .pllLocked(pllLocked),
  .pllLockRouted(pllLockRouted), .slowTickClock(slowTickClock),
  .crystalSubstituteTick(crystalSubstituteTick),
  .lowPowerMasterTick(lowPowerMasterTick), .hibernate(hibernate),
  .debugHalt(debugHalt), .ctwClear(ctwClear), .ctwIntEn(ctwIntEn),
  .ctwIntSel(ctwIntSel), .ctwCount(ctwCount), .ctwIntr(ctwIntr),
  .ftwEn(ftwEn), .ftwIntEn(ftwIntEn), .ftwTerminal(ftwTerminal),
  .ftwCount(ftwCount), .ftwIntr(ftwIntr));
`default_nettype wire

/* testbench/cktw_src_model.sv */
// oscillator and fabric clock pins seen by the clock tree
// assumes clk is the system clock; pins are divided from it
`timescale 1ns/100ps
`default_nettype none
module cktw_src_model (
  // clock
  input wire logic clk,
  // pins: periods of 4, 8 and 16 clk cycles
  output logic mainOsc,
  output logic lowOsc,
  output logic slowOsc
);
  logic [3:0] cnt = 4'h0;
  always @(posedge clk) cnt <= #1 cnt + 4'h1;
  assign mainOsc = cnt[1];
  assign lowOsc = cnt[2];
  assign slowOsc = cnt[3];
endmodule : cktw_src_model
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the clock tree and its dividers
// assumes the pin model; pll lock count shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cktw_pkg::*;
  localparam int LOCK = 20;
  logic clk = 1'b0, rst_b = 1'b0, mainOsc, lowOsc, slowOsc;
  logic pllEn = 1'b0, hibernate = 1'b0, debugHalt = 1'b0, ctwClear = 1'b0;
  logic ctwIntEn = 1'b0, ctwWakeEn = 1'b0, ftwEn = 1'b0, ftwIntEn = 1'b0;
  logic usbSel = 1'b0;
  logic [1:0] pllRefSel = REF_IMO, dblSel = REF_IMO;
  logic [PLL_FLD_W-1:0] pllInDiv = 6'h00, pllFbDiv = 6'h01;
  logic [CTW_SEL_W-1:0] ctwIntSel = 4'h1;
  logic [FTW_W-1:0] ftwTerminal = 5'h00;
  logic [SRC_SEL_W-1:0] masterSel = SRC_IMO;
  logic [DIV_W-1:0] busDiv = 16'h0003;
  logic [CPU_DIV_W-1:0] cpuDiv = 4'h2;
  logic [N_DIG*SRC_SEL_W-1:0] digSel = '0;
  logic [N_DIG*DIV_W-1:0] digDiv = '0;
  logic [N_ANA*SRC_SEL_W-1:0] anaSel = '0;
  logic [N_ANA*DIV_W-1:0] anaDiv = '0;
  logic [N_ANA*SKEW_W-1:0] anaSkew = '0;
  logic pllLocked, pllLockRouted, slowTickClock, crystalSubstituteTick;
  logic lowPowerMasterTick, ctwIntr, ctwWake, ftwIntr, busClk, cpuClk;
  logic usbClkTick, sleepTick, masterTick;
  logic [CTW_W-1:0] ctwCount;
  logic [FTW_W-1:0] ftwCount;
  logic [N_DIG-1:0] digClk;
  logic [N_ANA-1:0] anaClk;
  int error_cnt = 0, n_compared = 0;
  wire [19:0] obs = {masterTick, sleepTick, crystalSubstituteTick,
    lowPowerMasterTick,
    slowTickClock, usbClkTick, cpuClk, busClk, anaClk, digClk};
  cktw_src_model src (.clk(clk), .mainOsc(mainOsc), .lowOsc(lowOsc),
    .slowOsc(slowOsc));
  cktw_clock_tree #(.LOCK_CYCLES(LOCK)) dut (.clk(clk), .rst_b(rst_b),
    .internalMainOsc(mainOsc), .fastCrystalOsc(mainOsc), .routedClk(lowOsc),
    .lowSpeedOsc(lowOsc), .watchCrystalOsc(mainOsc), .routedUsbClk(slowOsc),
    .routedDirect({8{slowOsc}}), .pllEn(pllEn), .pllRefSel(pllRefSel),
    .pllInDiv(pllInDiv), .pllFbDiv(pllFbDiv), .pllLocked(pllLocked),
    .pllLockRouted(pllLockRouted), .slowTickClock(slowTickClock),
    .crystalSubstituteTick(crystalSubstituteTick),
    .lowPowerMasterTick(lowPowerMasterTick), .hibernate(hibernate),
    .debugHalt(debugHalt), .ctwClear(ctwClear), .ctwIntEn(ctwIntEn),
    .ctwWakeEn(ctwWakeEn), .ctwIntSel(ctwIntSel), .ctwCount(ctwCount),
    .ctwIntr(ctwIntr), .ctwWake(ctwWake), .ftwEn(ftwEn),
    .ftwIntEn(ftwIntEn), .ftwTerminal(ftwTerminal), .ftwCount(ftwCount),
    .ftwIntr(ftwIntr), .rtcSecond(), .sleepTimerTick(sleepTick),
    .masterSel(masterSel), .busDiv(busDiv), .cpuDiv(cpuDiv),
    .masterTick(masterTick), .busClk(busClk), .cpuClk(cpuClk),
    .digSel(digSel),
    .digDiv(digDiv), .digClk(digClk), .anaSel(anaSel), .anaDiv(anaDiv),
    .anaSkew(anaSkew), .anaClk(anaClk), .dblSel(dblSel), .usbSel(usbSel),
    .usbClkTick(usbClkTick));
  always #2 clk = ~clk;
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_hi(int idx);
    for (int n = 0; n < 5000 && obs[idx] !== 1'b1; n++) step();
  endtask : wait_hi
  // cycles from here to the next rising edge of one observed clock
  task automatic rise(int idx, output int n);
    n = 0;
    while (obs[idx] === 1'b1 && n < 5000) begin
      step();
      n++;
    end
    while (obs[idx] !== 1'b1 && n < 5000) begin
      step();
      n++;
    end
  endtask : rise
  task automatic period(int idx, int exp);
    int n;
    rise(idx, n);
    rise(idx, n);
    rise(idx, n);
    check(n, exp);
  endtask : period
  task automatic t_lowspd();
    int lastSub = -1, lastSlow = -1;
    for (int i = 0; i < 250; i++) begin
      wait_hi(16);
      if (obs[17] === 1'b1) begin
        if (lastSub >= 0) check(i - lastSub, SUB_DIV);
        lastSub = i;
      end
      if (obs[15] === 1'b1) begin
        if (lastSlow >= 0) check(i - lastSlow, SLOW_DIV);
        lastSlow = i;
      end
      step();
    end
  endtask : t_lowspd
  task automatic t_ftw();
    logic [4:0] term[3] = '{5'h00, 5'h03, 5'h1F};
    logic [4:0] prev;
    ftwEn = 1'b1;
    foreach (term[t]) begin
      ftwTerminal = term[t];
      ftwIntEn = (t != 1);
      for (int i = 0; i < 40; i++) begin
        prev = ftwCount;
        wait_hi(16);
        check(ftwCount, prev == term[t] ? 5'h00 : prev + 5'h01);
        check(ftwIntr, prev == term[t] && t != 1);
        step();
      end
    end
  endtask : t_ftw
  task automatic t_ctw();
    logic [12:0] prev;
    ctwIntEn = 1'b1;
    ctwWakeEn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      hibernate = (k == 2);
      debugHalt = (k == 3);
      wait_hi(15);
      prev = ctwCount;
      step();
      check(ctwCount, k < 2 ? prev + 13'h1 : prev);
      check({ctwIntr, ctwWake}, k < 2 ? {2{prev[0]}} : 2'h0);
    end
    hibernate = 1'b0;
    debugHalt = 1'b0;
    ctwClear = 1'b1;
    step();
    check(ctwCount, 13'h0);
    ctwClear = 1'b0;
  endtask : t_ctw
  task automatic t_pll();
    int n;
    digSel[2:0] = SRC_PLL;
    digDiv[15:0] = 16'h0004;
    for (int r = 0; r < 3; r++) begin
      pllRefSel = r[1:0];
      pllEn = 1'b1;
      for (n = 0; n < 200 && pllLocked !== 1'b1; n++) step();
      check(n >= LOCK && n <= LOCK + 4, 1'b1);
      check(pllLockRouted, 1'b1);
      period(0, r == 2 ? 16 : 8);
      pllEn = 1'b0;
      step();
      step();
      check(pllLocked, 1'b0);
    end
  endtask : t_pll
  task automatic t_div();
    int srcPer[8] = '{4, 4, 8, 0, 2, 8, 4, 16};
    for (int d = 0; d < 8; d++) begin
      digSel[d*3 +: 3] = d[2:0];
      digDiv[d*16 +: 16] = 16'(d + 2);
    end
    for (int a = 0; a < 4; a++) begin
      anaSel[a*3 +: 3] = a == 0 ? SRC_CHAIN : SRC_LOWSPD;
      anaDiv[a*16 +: 16] = 16'(a + 2);
      anaSkew[a*4 +: 4] = 4'(a);
    end
    for (int d = 0; d < 8; d++)
      if (d != 3) period(d, srcPer[d] * (d + 2));
    for (int a = 0; a < 4; a++) period(8 + a, 8 * (a + 2));
    period(12, 12);
    period(13, 24);
    period(19, 4);
    masterSel = SRC_LOWSPD;
    period(12, 24);
    period(19, 8);
    period(18, 4);
  endtask : t_div
  task automatic t_usb();
    int per[4] = '{2, 2, 4, 16};
    for (int u = 0; u < 4; u++) begin
      usbSel = (u < 3);
      dblSel = u[1:0];
      period(14, per[u]);
    end
  endtask : t_usb
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) step();
    rst_b = 1'b1;
    step();
    check({ctwCount, ftwCount, pllLocked}, 0);
    t_lowspd();
    t_ftw();
    t_ctw();
    t_pll();
    t_div();
    t_usb();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
